// [design/cpsm_map.svh]
// register offsets, field positions, reset values and link timing of the codec port
`ifndef CPSM_MAP_SVH
`define CPSM_MAP_SVH
`define CPSM_CTRL_ADR 4'h0
`define CPSM_STAT_ADR 4'h4
`define CPSM_ADR_MIN  4
`define CPSM_CTRL_W   12
`define CPSM_CTRL_RST 12'h000
`define CPSM_F_MODE   2:0
`define CPSM_F_EN     3
`define CPSM_F_SLAVE  4
`define CPSM_F_BULK   5
`define CPSM_F_BVM    6
`define CPSM_F_SREQ   7
`define CPSM_F_HALF   11:8
`define CPSM_S_BULK   0
`define CPSM_S_REFUSE 1
`define CPSM_S_PEND   2
`define CPSM_S_EN     3
`define CPSM_S_CNT    31:16
`define CPSM_SMP_W    24
`define CPSM_LAST_BIT 6'h3F
`define CPSM_HALF_OUT 4'h1
`endif

// [design/cpsm_pkg.sv]
// types shared by the codec port blocks
`include "cpsm_map.svh"
package cpsm_pkg;
  typedef enum logic [2:0] {
    CPSM_GP    = 3'h0,
    CPSM_AC97  = 3'h1,
    CPSM_PULSE = 3'h3,
    CPSM_I2S4  = 3'h4,
    CPSM_I2S5  = 3'h5
  } cpsm_mode_e;
  typedef logic [`CPSM_SMP_W-1:0] cpsm_smp_t;
  typedef struct packed {
    cpsm_smp_t left;
    cpsm_smp_t right;
  } cpsm_tx_s;
  typedef struct packed {
    cpsm_smp_t a_l;
    cpsm_smp_t a_r;
    cpsm_smp_t b_l;
    cpsm_smp_t b_r;
  } cpsm_raw_s;
  typedef struct packed {
    cpsm_smp_t s3;
    cpsm_smp_t s2;
    cpsm_smp_t s1;
    cpsm_smp_t s0;
  } cpsm_rx_s;
  typedef struct packed {
    cpsm_mode_e mode;
    logic       en;
    logic       slave;
    logic       bulk;
    logic       bvm;
    logic       sreq;
    logic [3:0] in_half;
  } cpsm_cfg_s;
endpackage

// [design/cpsm_tim.sv]
// bit clock divider and frame position counter for one side of the link
`timescale 1ns/1ps
`include "cpsm_map.svh"
module cpsm_tim (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [3:0] half_i,
  input  wire logic       hold_i,
  output logic            sclk_o,
  output logic            fall_o,
  output logic            rise_o,
  output logic [5:0]      bcnt_o,
  output logic [5:0]      nb_o
);
  import cpsm_pkg::*;
  logic [3:0] hcnt_r;
  logic       tick;

  // a half period of zero would stall the divider, so it counts as one
  assign tick = run_i && ((hcnt_r + 4'h1) >= ((half_i == 4'h0) ? 4'h1 : half_i));
  assign fall_o = tick && sclk_o;
  assign rise_o = tick && !sclk_o;
  // six-bit count wraps after 64 serial clocks
  assign nb_o = (fall_o && !(hold_i && bcnt_o == `CPSM_LAST_BIT)) ? bcnt_o + 6'h1 : bcnt_o;

  // half-period counter
  always_ff @(posedge clk_i)
    if (rst_i || !run_i)
      hcnt_r <= 4'h0;
    else if (tick)
      hcnt_r <= 4'h0;
    else
      hcnt_r <= hcnt_r + 4'h1;

  // serial clock idles low while stopped
  always_ff @(posedge clk_i)
    if (rst_i || !run_i)
      sclk_o <= 1'b0;
    else if (tick)
      sclk_o <= !sclk_o;

  // parked on the last bit so the first falling edge opens frame 0
  always_ff @(posedge clk_i)
    if (rst_i || !run_i)
      bcnt_o <= `CPSM_LAST_BIT;
    else
      bcnt_o <= nb_o;
endmodule

// [design/cpsm_top.sv]
// codec serial port: register slave, DMA slot mapping and link-side framing
`timescale 1ns/1ps
`include "cpsm_map.svh"
// Functional notes
// - every I2S data line carries left in slot 0, right in slot 1.
// - two-input mode: first line to DMA slots 0 and 2, second to 1 and 3.
// - two-input mode: DMA slot 0 is sent left, slot 1 right.
// - independent-clock mode: output and second input use slot 0 left, 1 right.
// - pulse mode frame sync lasts exactly one serial clock period.
// - master option takes codec frame sync; slave option drives it.
// - no second stream for codec register programming is ever output.
// - secondary request only by the separate high flag, never the data LSB.
// - pulse mode drives clock, data out, reset, and sync in the slave option; samples data in.
// - bulk OUT only in AC '97 or general-purpose mode, one DMA channel.
// - AC '97 bulk marks each slot valid or invalid by its tag bit.
// - general-purpose bulk drops frame sync for frames without valid data.
// - I2S frame clock low in left slot, high in right slot.
// - each I2S slot is 32 serial clocks, a frame 64.
module cpsm_top #(
  parameter int ADR_W = 4
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                dma_tx_valid_i,
  input  wire cpsm_pkg::cpsm_tx_s  dma_tx_i,
  output logic                     dma_tx_ready_o,
  output logic                     dma_rx_valid_o,
  output cpsm_pkg::cpsm_rx_s       dma_rx_o,
  input  wire logic                link_clk_i,
  input  wire logic                codec_frame_sync_i,
  output logic                     codec_frame_sync_o,
  output logic                     codec_frame_sync_oe_o,
  output logic                     codec_serial_clock_o,
  output logic                     codec_data_out_o,
  input  wire logic                codec_data_in_i,
  output logic                     codec_reset_out_o,
  input  wire logic                secondary_channel_enable_i,
  output logic                     secondary_channel_enable_o,
  output logic                     secondary_channel_enable_oe_o
);
  import cpsm_pkg::*;
  localparam int SW  = `CPSM_SMP_W;
  localparam int CVW = $bits(cpsm_cfg_s) + 2;

  // the decoder needs room for every register offset
  if (ADR_W < `CPSM_ADR_MIN)
  begin : g_chk
    $error("cpsm_top: ADR_W too small for the register map");
  end

  // ---------------- system clock domain ----------------
  logic [`CPSM_CTRL_W-1:0] ctrl_r;
  cpsm_cfg_s               cfg_r;
  cpsm_mode_e              mode;
  logic                    bulk_ok;
  logic                    acc;
  logic [31:0]             stat_w;
  logic                    req_r;
  cpsm_tx_s                hold_r;
  logic                    take;
  logic [2:0]              as_r;
  logic                    ackq_r;
  logic [2:0]              rs_r;
  logic                    rxq_r;
  logic                    rxp_r;
  logic                    evt;
  logic [15:0]             frm_cnt_r;

  // ---------------- link clock domain ----------------
  logic [CVW-1:0] ls1_r;
  logic [CVW-1:0] ls2_r;
  logic [CVW-1:0] ls3_r;
  logic           lrst;
  logic           lreq;
  cpsm_cfg_s      lcfg;
  logic           ack_r;
  logic           fvalid_r;
  cpsm_tx_s       txw_r;
  logic           fs_seen_r;
  logic [SW-1:0]  sha_r;
  logic [SW-1:0]  shb_r;
  logic [SW-1:0]  al_r;
  logic [SW-1:0]  bl_r;
  cpsm_raw_s      rxw_r;
  logic           rxt_r;
  wire  [1:0]     sclk;
  wire  [1:0]     fall;
  wire  [1:0]     rise;
  wire  [5:0]     bcnt [2];
  wire  [5:0]     nb [2];
  logic           i2s;
  logic           i2s5;
  logic           pulse;
  logic           mwait;
  logic           fstart;
  logic           vnow;
  logic           fv;
  logic [4:0]     p;
  logic [4:0]     idx;
  cpsm_smp_t      word;
  logic           bit_nxt;
  logic           sync_nxt;
  logic           in_edge;
  logic [5:0]     in_pos;
  logic [4:0]     pi;
  logic [SW-1:0]  sa_n;
  logic [SW-1:0]  sb_n;

  assign mode = cpsm_mode_e'(ctrl_r[`CPSM_F_MODE]);
  // bulk OUT only where validity can be signalled
  assign bulk_ok = (mode == CPSM_AC97) || (mode == CPSM_GP);
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // one wait state: ack follows the request edge and drops the cycle after
  always_ff @(posedge clk_i)
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= acc;

  // control register; fields sit in byte lanes 0 and 1
  always_ff @(posedge clk_i)
    if (rst_i)
      ctrl_r <= `CPSM_CTRL_RST;
    else if (acc && wb_we_i && wb_adr_i == ADR_W'(`CPSM_CTRL_ADR))
    begin
      if (wb_sel_i[0])
        ctrl_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        ctrl_r[11:8] <= wb_dat_i[11:8];
    end

  // status word assembled from live state
  always_comb
  begin
    stat_w = 32'h0;
    stat_w[`CPSM_S_BULK] = cfg_r.bulk;
    stat_w[`CPSM_S_REFUSE] = ctrl_r[`CPSM_F_BULK] && !bulk_ok;
    stat_w[`CPSM_S_PEND] = req_r != ackq_r;
    stat_w[`CPSM_S_EN] = cfg_r.en;
    stat_w[`CPSM_S_CNT] = frm_cnt_r;
  end

  // read data is registered with ack; unmapped offsets read zero
  always_ff @(posedge clk_i)
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (acc && !wb_we_i)
    begin
      if (wb_adr_i == ADR_W'(`CPSM_CTRL_ADR))
        wb_dat_o <= {20'h0, ctrl_r};
      else if (wb_adr_i == ADR_W'(`CPSM_STAT_ADR))
        wb_dat_o <= stat_w;
      else
        wb_dat_o <= 32'h0;
    end

  // configuration handed to the link; bulk is dropped in modes that refuse it
  always_ff @(posedge clk_i)
    if (rst_i)
      cfg_r <= '0;
    else
    begin
      cfg_r.mode <= mode;
      cfg_r.en <= ctrl_r[`CPSM_F_EN];
      cfg_r.slave <= ctrl_r[`CPSM_F_SLAVE];
      cfg_r.bulk <= ctrl_r[`CPSM_F_BULK] && bulk_ok;
      cfg_r.bvm <= ctrl_r[`CPSM_F_BVM];
      cfg_r.sreq <= ctrl_r[`CPSM_F_SREQ];
      cfg_r.in_half <= ctrl_r[`CPSM_F_HALF];
    end

  assign take = dma_tx_valid_i && dma_tx_ready_o;

  // left word is DMA slot 0, right word slot 1
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      req_r <= 1'b0;
      hold_r <= '0;
    end
    else if (take)
    begin
      req_r <= !req_r;
      hold_r <= dma_tx_i;
    end

  // one word in flight; ready returns only after the link acknowledged it
  always_ff @(posedge clk_i)
    if (rst_i)
      dma_tx_ready_o <= 1'b0;
    else
      dma_tx_ready_o <= !take && (req_r == ackq_r);

  // acknowledge and receive toggles cross on three flops each
  always_ff @(posedge clk_i)
  begin
    as_r <= {as_r[1:0], ack_r};
    rs_r <= {rs_r[1:0], rxt_r};
  end

  // a toggle counts once the last two stages agree
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      ackq_r <= 1'b0;
      rxq_r <= 1'b0;
      rxp_r <= 1'b0;
    end
    else
    begin
      if (as_r[1] == as_r[2])
        ackq_r <= as_r[2];
      if (rs_r[1] == rs_r[2])
        rxq_r <= rs_r[2];
      rxp_r <= rxq_r;
    end

  assign evt = rxq_r != rxp_r;

  // received words are stable for a whole frame, far longer than the crossing
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      dma_rx_valid_o <= 1'b0;
      dma_rx_o <= '0;
      frm_cnt_r <= 16'h0;
    end
    else
    begin
      dma_rx_valid_o <= evt;
      if (evt)
      begin
        frm_cnt_r <= frm_cnt_r + 16'h1;
        // two inputs interleave into four DMA slots
        if (mode == CPSM_I2S4)
          dma_rx_o <= '{s0: rxw_r.a_l, s1: rxw_r.b_l, s2: rxw_r.a_r, s3: rxw_r.b_r};
        // single input keeps left in slot 0, right in slot 1
        else
          dma_rx_o <= '{s0: rxw_r.a_l, s1: rxw_r.a_r, s2: '0, s3: '0};
      end
    end

  // ---------------- link side ----------------
  // reset, request toggle and configuration cross on three flops
  always_ff @(posedge link_clk_i)
  begin
    ls1_r <= {rst_i, req_r, cfg_r};
    ls2_r <= ls1_r;
    ls3_r <= ls2_r;
  end

  // configuration is quasi-static; change it only while the port is off
  always_ff @(posedge link_clk_i)
    if (ls2_r == ls3_r)
      {lrst, lreq, lcfg} <= ls3_r;

  assign i2s = (lcfg.mode == CPSM_I2S4) || (lcfg.mode == CPSM_I2S5);
  assign i2s5 = lcfg.mode == CPSM_I2S5;
  assign pulse = lcfg.mode == CPSM_PULSE;
  // master option waits for the codec's sync before a new frame
  assign mwait = pulse && !lcfg.slave && !fs_seen_r;

  // side 0 times the output, side 1 the input in independent-clock mode
  for (genvar s = 0; s < 2; s++)
  begin : g_side
    cpsm_tim u_tim (
      .clk_i  (link_clk_i),
      .rst_i  (lrst),
      .run_i  (lcfg.en),
      .half_i ((s == 1 && i2s5) ? lcfg.in_half : `CPSM_HALF_OUT),
      .hold_i ((s == 0) ? mwait : 1'b0),
      .sclk_o (sclk[s]),
      .fall_o (fall[s]),
      .rise_o (rise[s]),
      .bcnt_o (bcnt[s]),
      .nb_o   (nb[s])
    );
  end

  assign fstart = fall[0] && nb[0] == 6'h00;
  assign vnow = lreq != ack_r;
  assign fv = fstart ? vnow : fvalid_r;
  assign p = nb[0][4:0];
  assign idx = 5'(SW) - p;
  // left word in slot 0, right word in slot 1
  assign word = nb[0][5] ? txw_r.right : txw_r.left;

  // codec-sourced sync is caught on the rising serial clock edge
  always_ff @(posedge link_clk_i)
    if (lrst || fstart)
      fs_seen_r <= 1'b0;
    else if (rise[0] && codec_frame_sync_i)
      fs_seen_r <= 1'b1;

  // a pending word is taken only at a frame boundary
  always_ff @(posedge link_clk_i)
    if (lrst)
    begin
      ack_r <= 1'b0;
      fvalid_r <= 1'b0;
      txw_r <= '0;
    end
    else if (fstart)
    begin
      fvalid_r <= vnow;
      if (vnow)
      begin
        txw_r <= hold_r;
        ack_r <= lreq;
      end
    end

  // bit after this falling edge: lead bit, then sample MSB first, then zeros
  always_comb
  begin
    bit_nxt = 1'b0;
    // in AC '97 mode the lead bit of each slot carries its valid tag
    // with bulk set, tag honoured only with valid marking set
    if (p == 5'h00)
      bit_nxt = (lcfg.mode == CPSM_AC97) && fv && (!lcfg.bulk || lcfg.bvm);
    else if (p <= 5'(SW))
      bit_nxt = word[idx];
  end

  // frame sync level for the coming serial clock period
  always_comb
  begin
    // low in left slot, high in right slot
    if (i2s)
      sync_nxt = nb[0][5];
    // one serial clock period at frame start
    // general-purpose bulk drops sync for empty frames
    else
      sync_nxt = (nb[0] == 6'h00)
        && !((lcfg.mode == CPSM_GP) && lcfg.bulk && lcfg.bvm && !fv);
  end

  // single data line; output changes on the falling serial clock edge
  // pins idle low while disabled so a restart never leaves a stale sync level
  always_ff @(posedge link_clk_i)
    if (lrst || !lcfg.en)
    begin
      codec_frame_sync_o <= 1'b0;
      codec_data_out_o <= 1'b0;
    end
    else if (fall[0])
    begin
      codec_frame_sync_o <= sync_nxt;
      codec_data_out_o <= bit_nxt;
    end

  // pin directions follow the selected mode
  always_ff @(posedge link_clk_i)
    if (lrst)
    begin
      codec_frame_sync_oe_o <= 1'b0;
      codec_reset_out_o <= 1'b0;
      secondary_channel_enable_o <= 1'b0;
      secondary_channel_enable_oe_o <= 1'b0;
    end
    else
    begin
      // sync is driven except in the pulse master option
      codec_frame_sync_oe_o <= lcfg.en && !(pulse && !lcfg.slave);
      // reset pin carries the input bit clock in independent-clock mode
      codec_reset_out_o <= i2s5 ? (sclk[1] ^ (fall[1] | rise[1])) : lcfg.en;
      // secondary request is a plain level
      // channel-enable pin sources that level in pulse mode
      secondary_channel_enable_o <= i2s5 ? nb[1][5] : (pulse && lcfg.sreq);
      secondary_channel_enable_oe_o <= lcfg.en && (i2s5 || pulse);
    end

  assign codec_serial_clock_o = sclk[0];
  assign in_edge = i2s5 ? rise[1] : rise[0];
  assign in_pos = i2s5 ? bcnt[1] : bcnt[0];
  assign pi = in_pos[4:0];
  assign sa_n = {sha_r[SW-2:0], codec_data_in_i};
  assign sb_n = {shb_r[SW-2:0], secondary_channel_enable_i};

  // input shifts on the rising edge; inputs are synchronous to our own clock
  always_ff @(posedge link_clk_i)
    if (lrst)
    begin
      sha_r <= '0;
      shb_r <= '0;
      al_r <= '0;
      bl_r <= '0;
      rxw_r <= '0;
      rxt_r <= 1'b0;
    end
    else if (in_edge && pi != 5'h00 && pi <= 5'(SW))
    begin
      sha_r <= sa_n;
      shb_r <= sb_n;
      if (pi == 5'(SW))
      begin
        // left slot held until the right slot completes the frame
        if (!in_pos[5])
        begin
          al_r <= sa_n;
          bl_r <= sb_n;
        end
        else
        begin
          rxw_r <= '{a_l: al_r, a_r: sa_n, b_l: bl_r, b_r: sb_n};
          rxt_r <= !rxt_r;
        end
      end
    end
endmodule

// [test/cpsm_top_asserts.sv]
// concurrent checks on the codec port top-level ports
`timescale 1ns/1ps
`include "cpsm_map.svh"
module cpsm_top_asserts #(
  parameter int ADR_W = 4
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             dma_tx_valid_i,
  input wire logic             dma_tx_ready_o,
  input wire logic             dma_rx_valid_o,
  input wire logic             link_clk_i,
  input wire logic             codec_frame_sync_o,
  input wire logic             codec_frame_sync_oe_o,
  input wire logic             codec_serial_clock_o,
  input wire logic             secondary_channel_enable_o,
  input wire logic             secondary_channel_enable_oe_o
);
  logic [11:0] ctrl_r;
  logic        sclk_q;
  logic        sync_q;
  logic        seen_r;
  logic [6:0]  cnt_r;
  logic        i2s;
  logic        refuse;
  // shadow of the control word; the link checks need the mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= 12'h000;
    else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `CPSM_CTRL_ADR)
      ctrl_r <= wb_dat_i[11:0];
  end
  assign i2s    = ctrl_r[2] && ctrl_r[3];
  assign refuse = ctrl_r[5] && (ctrl_r[2:0] == 3'h3 || ctrl_r[2:0] == 3'h4 || ctrl_r[2:0] == 3'h5);
  // serial clock rises since the last frame clock edge; first edge only arms it
  always_ff @(posedge link_clk_i)
  begin
    sclk_q <= codec_serial_clock_o;
    sync_q <= codec_frame_sync_o;
    if (rst_i || !i2s)
    begin
      seen_r <= 1'b0;
      cnt_r  <= 7'h00;
    end
    else if (codec_frame_sync_o != sync_q)
    begin
      seen_r <= 1'b1;
      cnt_r  <= 7'h00;
    end
    else if (codec_serial_clock_o && !sclk_q)
      cnt_r <= cnt_r + 7'h01;
  end
  sequence s_pulse_cfg;
    $changed(ctrl_r) && ctrl_r[2:0] == 3'h3 && ctrl_r[3];
  endsequence
  sequence s_one_period;
    codec_frame_sync_o ##1 !codec_frame_sync_o;
  endsequence
  chk_ack_next_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not one cycle after request");
  chk_ack_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  chk_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i != `CPSM_CTRL_ADR && wb_adr_i != `CPSM_STAT_ADR
    |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  chk_bulk_refuse_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == `CPSM_STAT_ADR |-> wb_dat_o[1] == refuse)
    else $error("bulk refuse flag wrong for mode");
  chk_tx_take_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_tx_valid_i && dma_tx_ready_o |=> !dma_tx_ready_o) else $error("ready held after take");
  chk_rx_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_rx_valid_o |=> !dma_rx_valid_o) else $error("rx valid longer than one cycle");
  chk_secondary_flag_out: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pulse_cfg |-> ##[1:600] (secondary_channel_enable_oe_o
    && secondary_channel_enable_o == ctrl_r[7])) else $error("secondary flag not driven");
  chk_slave_drives_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pulse_cfg ##0 ctrl_r[4] |-> ##[1:600] codec_frame_sync_oe_o)
    else $error("slave option does not drive sync");
  chk_master_takes_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pulse_cfg ##0 !ctrl_r[4] |-> ##[1:600] !codec_frame_sync_oe_o)
    else $error("master option drives sync");
  chk_sync_one_period: assert property (@(posedge link_clk_i) disable iff (rst_i)
    !ctrl_r[2] && ctrl_r[3] && codec_frame_sync_oe_o && $rose(codec_frame_sync_o)
    |=> s_one_period) else $error("sync pulse not one serial period");
  chk_slot_32_clocks: assert property (@(posedge link_clk_i) disable iff (rst_i)
    seen_r && codec_frame_sync_o != sync_q |-> cnt_r == 7'h20)
    else $error("slot length not 32 serial clocks");
endmodule
bind cpsm_top cpsm_top_asserts #(.ADR_W(ADR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dma_tx_valid_i(dma_tx_valid_i), .dma_tx_ready_o(dma_tx_ready_o),
  .dma_rx_valid_o(dma_rx_valid_o), .link_clk_i(link_clk_i),
  .codec_frame_sync_o(codec_frame_sync_o), .codec_frame_sync_oe_o(codec_frame_sync_oe_o),
  .codec_serial_clock_o(codec_serial_clock_o),
  .secondary_channel_enable_o(secondary_channel_enable_o),
  .secondary_channel_enable_oe_o(secondary_channel_enable_oe_o));

// [test/cpsm_codec_line.sv]
// codec model for one serial data line: captures device data, answers with a pattern
`timescale 1ns/1ps
module cpsm_codec_line #(
  parameter logic [23:0] PAT_L = 24'h000000,
  parameter logic [23:0] PAT_R = 24'h000000
) (
  input  wire logic   sclk_i,
  input  wire logic   sync_i,
  input  wire logic   sd_i,
  output logic        sd_o,
  output logic [23:0] cap_l_o,
  output logic [23:0] cap_r_o
);
  logic        sync_q = 1'b0;
  logic [23:0] sh_q   = 24'h000000;
  int          pos_q  = 40;
  initial sd_o = 1'b0;
  // slot by frame clock level, position restarts at each edge
  always @(posedge sclk_i)
  begin : smp
    int p;
    p = (sync_i != sync_q) ? 0 : pos_q + 1;
    sh_q <= {sh_q[22:0], sd_i};
    if (p == 24 && sync_i)
      cap_r_o <= {sh_q[22:0], sd_i};
    if (p == 24 && !sync_i)
      cap_l_o <= {sh_q[22:0], sd_i};
    pos_q  <= p;
    sync_q <= sync_i;
  end
  // answer msb first one bit after the edge; elsewhere the line is not held
  always @(negedge sclk_i)
  begin : drv
    int np;
    np = pos_q + 1;
    if (np >= 1 && np <= 24)
      sd_o <= sync_q ? PAT_R[24-np] : PAT_L[24-np];
    else
      sd_o <= ~sd_o;
  end
endmodule

// [test/cpsm_top_tb.sv]
// self-checking bench for the codec port top level
`timescale 1ns/1ps
`include "cpsm_map.svh"
module cpsm_top_tb;
  import cpsm_pkg::*;
  localparam logic [23:0] AL = 24'hA5C3E1, AR = 24'h5A3C1E, BL = 24'h123456, BR = 24'h789ABC;
  localparam logic [23:0] CL = 24'h0F1E2D, CR = 24'h3C4B5A, TL = 24'h9ABCDE, TR = 24'h2468AC;
  logic        clk_i, rst_i, link_clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        dma_tx_valid_i, dma_tx_ready_o, dma_rx_valid_o, fs_i, fs_o, fs_oe, sclk;
  logic        dout, din, crst, sce_i, sce_o, sce_oe, sd1, sd3;
  logic [23:0] cap_l, cap_r;
  cpsm_tx_s    dma_tx_i;
  cpsm_rx_s    dma_rx_o;
  int          miscompares, tests_run, n;
  cpsm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_tx_valid_i(dma_tx_valid_i),
    .dma_tx_i(dma_tx_i), .dma_tx_ready_o(dma_tx_ready_o), .dma_rx_valid_o(dma_rx_valid_o),
    .dma_rx_o(dma_rx_o), .link_clk_i(link_clk_i), .codec_frame_sync_i(fs_i),
    .codec_frame_sync_o(fs_o), .codec_frame_sync_oe_o(fs_oe), .codec_serial_clock_o(sclk),
    .codec_data_out_o(dout), .codec_data_in_i(din), .codec_reset_out_o(crst),
    .secondary_channel_enable_i(sce_i), .secondary_channel_enable_o(sce_o),
    .secondary_channel_enable_oe_o(sce_oe));
  // output line plus first input, second input, and input side of the independent mode
  cpsm_codec_line #(.PAT_L(AL), .PAT_R(AR)) u_c1 (.sclk_i(sclk), .sync_i(fs_o), .sd_i(dout),
    .sd_o(sd1), .cap_l_o(cap_l), .cap_r_o(cap_r));
  cpsm_codec_line #(.PAT_L(BL), .PAT_R(BR)) u_c2 (.sclk_i(sclk), .sync_i(fs_o), .sd_i(1'b0),
    .sd_o(sce_i), .cap_l_o(), .cap_r_o());
  cpsm_codec_line #(.PAT_L(CL), .PAT_R(CR)) u_c3 (.sclk_i(crst), .sync_i(sce_o), .sd_i(1'b0),
    .sd_o(sd3), .cap_l_o(), .cap_r_o());
  // the data-in pin is fed by u_c3 while sce_oe is high, otherwise by u_c1
  assign din = sce_oe ? sd3 : sd1;
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #1.3;
    forever #80 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64)
      chk("wb ack", 96'h1, 96'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  // port off long enough for the link side to see it before the next mode
  task automatic off;
    wb(1'b1, 4'h0, 32'h0);
    repeat (300) @(posedge clk_i);
  endtask
  task automatic wait_rx(input int k);
    repeat (k)
    begin
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (dma_rx_valid_o !== 1'b1 && n < 20000);
      if (n >= 20000)
        chk("rx pulse", 96'h1, 96'h0);
    end
  endtask
  task automatic count_sync(input int k);
    n = 0;
    repeat (k)
    begin
      @(posedge clk_i);
      if (fs_o === 1'b1)
        n++;
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard sized for about sixty thousand cycles of tests
  initial
  begin
    repeat (95000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i, dma_tx_valid_i, fs_i} = {4'h0, 4'h3, 32'h0, 2'b00};
    dma_tx_i = {TL, TR};
    tests_run = 0;
    miscompares = 0;
    // link side needs several of its own edges to see reset
    repeat (200) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", 96'h0, rd);
    wb(1'b0, 4'h4, 32'h0);
    chk("stat reset", 96'h0, rd);
    wb(1'b1, 4'h8, 32'hFFFFFFFF);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped read", 96'h0, rd);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl after unmapped write", 96'h0, rd);
    dma_tx_valid_i <= 1'b1;
    wb(1'b1, 4'h0, 32'h0000000C);
    wait_rx(3);
    chk("rx two inputs", {BR, AR, BL, AL}, dma_rx_o);
    chk("tx two inputs", {48'h0, TL, TR}, {48'h0, cap_l, cap_r});
    off();
    wb(1'b1, 4'h0, 32'h0000020D);
    wait_rx(3);
    chk("rx independent", {48'h0, CR, CL}, dma_rx_o);
    chk("tx independent", {48'h0, TL, TR}, {48'h0, cap_l, cap_r});
    dma_tx_valid_i <= 1'b0;
    off();
    wb(1'b1, 4'h0, 32'h0000009B);
    repeat (5000) @(posedge clk_i);
    chk("flag pin", 96'h3, {94'h0, sce_oe, sce_o});
    chk("slave sync drive", 96'h1, {95'h0, fs_oe});
    wb(1'b0, 4'h4, 32'h0);
    chk("word drained", 96'h0, {95'h0, rd[2]});
    off();
    wb(1'b1, 4'h0, 32'h0000000B);
    count_sync(800);
    chk("master waits for sync", 96'h0, 96'(n));
    chk("master sync input", 96'h2, {94'h0, sce_oe, fs_oe});
    fs_i <= 1'b1;
    wait_rx(1);
    chk("master frame on sync", 96'h1, {95'h0, n < 20000});
    off();
    wb(1'b1, 4'h0, 32'h0000002C);
    wb(1'b0, 4'h4, 32'h0);
    chk("bulk refused", 96'h1, {95'h0, rd[1]});
    off();
    wb(1'b1, 4'h0, 32'h00000068);
    wb(1'b0, 4'h4, 32'h0);
    chk("bulk accepted", 96'h1, {94'h0, rd[1:0]});
    count_sync(9000);
    chk("no word no sync", 96'h0, 96'(n));
    dma_tx_valid_i <= 1'b1;
    count_sync(9000);
    chk("word gives sync", 96'h1, {95'h0, n != 0});
    give_verdict();
  end
endmodule
